// ===== hw/irq_ctrl_pkg.sv
// Shared constants for the interrupt flag, mask and priority block
package irq_ctrl_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_SRC = 16; // Sources: low byte plus high byte
	localparam int NUM_PIN = 6; // External pin sources

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_REQ_LO = 8'h00; // req_flags_lo0
	localparam logic [7:0] OFS_REQ_HI = 8'h04; // req_flags_hi0
	localparam logic [7:0] OFS_MASK_LO = 8'h08; // mask_flags_lo0
	localparam logic [7:0] OFS_MASK_HI = 8'h0c; // mask_flags_hi0
	localparam logic [7:0] OFS_PRIO_A_LO = 8'h10; // prio_a_lo0
	localparam logic [7:0] OFS_PRIO_A_HI = 8'h14; // prio_a_hi0
	localparam logic [7:0] OFS_PRIO_B_LO = 8'h18; // prio_b_lo0
	localparam logic [7:0] OFS_PRIO_B_HI = 8'h1c; // prio_b_hi0
	localparam logic [7:0] OFS_RISE = 8'h20; // rise_edge_enable
	localparam logic [7:0] OFS_FALL = 8'h24; // fall_edge_enable
	localparam logic [7:0] OFS_CPU_STAT = 8'h28; // processor_status_word
	localparam logic [7:0] OFS_DMODE0 = 8'h2c; // dma_mode_reg, channel 0
	localparam logic [7:0] OFS_DMODE1 = 8'h30; // dma_mode_reg, channel 1
	localparam logic [7:0] OFS_STAT = 8'h34; // Sticky status, read only
	localparam logic [7:0] OFS_CLR = 8'h38; // Status clear, write only
	localparam logic [7:0] OFS_IEN = 8'h3c; // Status enable

	// ----------------------------------------------------------------
	// Flag positions in the 16-bit source vector (high byte = +8)
	// ----------------------------------------------------------------
	localparam int BIT_WDT = 0; // watchdog_interval_irq
	localparam int BIT_LVI = 1; // low_voltage_irq
	localparam int BIT_PIN0 = 2; // pin_irq_0, pins follow upward
	localparam int BIT_ST3 = 8; // Serial 3 transmit end
	localparam int BIT_SR3 = 9; // Serial 3 receive end
	localparam int BIT_SRE3 = 10; // Serial 3 receive error
	localparam int BIT_DMA0 = 11; // dma_ch0_end_irq
	localparam int BIT_DMA1 = 12; // DMA channel 1 end
	localparam int BIT_SER0_TX = 13; // High byte bit 5, shared
	localparam int BIT_SER0_RX = 14; // High byte bit 6, shared
	localparam int BIT_SRE0 = 15; // Serial 0 receive error

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CPU_STAT_IE_BIT = 7; // Global interrupt enable
	localparam int CPU_STAT_ISP_LSB = 1; // Two-bit in-service priority
	localparam int DMODE_EN_BIT = 7; // Channel enable
	localparam int ST_OVERRUN = 0; // DMA trigger while channel busy
	localparam int ST_LOST = 1; // Event on an already set flag

	// ----------------------------------------------------------------
	// DMA trigger select codes (bits 3..0 of the mode register)
	// ----------------------------------------------------------------
	localparam logic [3:0] DSEL_SER0_TX = 4'h6; // 0110B: sync_ser0 end
	localparam logic [3:0] DSEL_SER0_RX = 4'h7;
	localparam logic [3:0] DSEL_ST3 = 4'h8;
	localparam logic [3:0] DSEL_SR3 = 4'h9;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_REQ = 16'h0000;
	localparam logic [15:0] RST_MASK = 16'hffff; // All masked
	localparam logic [15:0] RST_PRIO = 16'hffff; // Lowest level
	localparam logic [5:0] RST_EDGE = 6'h00;
	localparam logic [7:0] RST_CPU_STAT = 8'h06; // IE off, ISP lowest
	localparam logic [7:0] RST_DMODE = 8'h00;
	localparam logic [1:0] RST_STAT = 2'h0;

endpackage : irq_ctrl_pkg

// ===== hw/pin_edge_detect.sv
// Pin synchroniser and edge detector for the external pin sources
`timescale 1ns/1ps
module pin_edge_detect (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [irq_ctrl_pkg::NUM_PIN-1:0] pin,
	input wire logic [irq_ctrl_pkg::NUM_PIN-1:0] rise_en,
	input wire logic [irq_ctrl_pkg::NUM_PIN-1:0] fall_en,
	output logic [irq_ctrl_pkg::NUM_PIN-1:0] evt
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [irq_ctrl_pkg::NUM_PIN-1:0] meta; // First stage, read by sync only
		logic [irq_ctrl_pkg::NUM_PIN-1:0] sync; // Second stage
		logic [irq_ctrl_pkg::NUM_PIN-1:0] prev; // Last synced level
	} pin_state_t;

	pin_state_t s_r; // Registered state
	pin_state_t s_nxt; // Next state

	// Shift pins through the two stages and remember the old level
	always_comb begin
		s_nxt = s_r;
		s_nxt.meta = pin;
		s_nxt.sync = s_r.meta;
		s_nxt.prev = s_r.sync;
	end

	// Pins read low until sync; a high pin at release looks like a rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Per-pin edge selection
	// ----------------------------------------------------------------
	for (genvar i = 0; i < irq_ctrl_pkg::NUM_PIN; i++) begin : g_pin
		assign evt[i] = (rise_en[i] & s_r.sync[i] & ~s_r.prev[i])
			| (fall_en[i] & ~s_r.sync[i] & s_r.prev[i]);
	end

endmodule : pin_edge_detect

// ===== hw/irq_flag_ctrl.sv
// Interrupt request flags, masks, priorities and DMA start triggers
// Function
// - Six register kinds steer interrupt handling
// - One latched request flag per source
// - Mask bit mirrors request flag position
// - Two priority bits form level code
// - Separate rising and falling pin enables
// - Serial 0 transmit events share bit 5
// - Serial 0 receive events share bit 6
// - Four-bit select picks DMA trigger
// - Shared trigger: channel 0 before 1
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module irq_flag_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Peripheral events, one-cycle pulses on pclk
	input wire logic watchdog_interval_irq,
	input wire logic low_voltage_irq,
	input wire logic ser3_tx_end_irq,
	input wire logic ser3_rx_end_irq,
	input wire logic ser3_rx_err_irq,
	input wire logic async0_tx_end_irq,
	input wire logic sync_ser0_end_irq,
	input wire logic async0_rx_end_irq,
	input wire logic sync_ser1_end_irq,
	input wire logic ser0_rx_err_irq,
	// External pins, asynchronous
	input wire logic [irq_ctrl_pkg::NUM_PIN-1:0] pin_irq,
	// DMA handshake
	input wire logic dma_done0,
	input wire logic dma_done1,
	output logic dma_req0,
	output logic dma_req1,
	// CPU side
	input wire logic cpu_ack,
	input wire logic [3:0] cpu_ack_idx,
	output logic irq_req,
	output logic [3:0] irq_idx,
	output logic [1:0] irq_lvl,
	// Block interrupt
	output logic int_out
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] req; // Request flags
		logic [15:0] mask; // Mask flags, 1 = masked
		logic [15:0] pa; // Priority bit 0 per source
		logic [15:0] pb; // Priority bit 1 per source
		logic [5:0] rise; // Rising edge enables
		logic [5:0] fall; // Falling edge enables
		logic [7:0] cpu_stat; // Status word
		logic [7:0] dmode0; // DMA channel 0 mode
		logic [7:0] dmode1; // DMA channel 1 mode
		logic [1:0] stat; // Sticky block status
		logic [1:0] ien; // Status enables
		logic pend1; // Channel 1 waits behind channel 0
		logic dreq0; // DMA request, channel 0
		logic dreq1; // DMA request, channel 1
		logic irq; // Request to CPU
		logic [3:0] idx; // Winning source
		logic [1:0] lvl; // Its level
		logic intr; // Block interrupt line
		logic rdy; // APB ready
		logic err; // APB error
		logic [31:0] rdata; // APB read data
	} state_t;

	localparam state_t RST_STATE = '{
		req: irq_ctrl_pkg::RST_REQ,
		mask: irq_ctrl_pkg::RST_MASK,
		pa: irq_ctrl_pkg::RST_PRIO,
		pb: irq_ctrl_pkg::RST_PRIO,
		rise: irq_ctrl_pkg::RST_EDGE,
		fall: irq_ctrl_pkg::RST_EDGE,
		cpu_stat: irq_ctrl_pkg::RST_CPU_STAT,
		dmode0: irq_ctrl_pkg::RST_DMODE,
		dmode1: irq_ctrl_pkg::RST_DMODE,
		stat: irq_ctrl_pkg::RST_STAT,
		ien: irq_ctrl_pkg::RST_STAT,
		default: '0
	};

	state_t s_r; // Registered state
	state_t s_nxt; // Next state

	logic [5:0] pin_evt; // Qualified pin edges
	logic [15:0] evt; // New events this cycle
	logic [15:0] ack_clr; // Flags the CPU takes
	logic [15:0] req_base; // Flags after software write
	logic [15:0] pend_v; // Set and unmasked
	logic [31:0] rd_mux; // Read data for current address
	logic rd_hit; // Address is mapped
	logic wr; // Write takes effect this edge
	logic trig0; // Channel 0 trigger
	logic trig1; // Channel 1 trigger
	logic same; // Both channels on one source
	logic [1:0] st_evt; // Status events
	logic found; // Some source is pending
	logic [1:0] best_lvl; // Best level so far
	logic [3:0] best_idx; // Best source so far

	// ----------------------------------------------------------------
	// Pin edges
	// ----------------------------------------------------------------
	pin_edge_detect u_pins (
		.pclk(pclk),
		.presetn(presetn),
		.pin(pin_irq),
		.rise_en(s_r.rise),
		.fall_en(s_r.fall),
		.evt(pin_evt)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Source event matching a trigger code; unknown codes never fire
	function automatic logic sel_hit(input logic [3:0] sel, input logic [15:0] e);
		logic r;
		r = 1'b0;
		unique case (sel)
			irq_ctrl_pkg::DSEL_SER0_TX: r = e[irq_ctrl_pkg::BIT_SER0_TX];
			irq_ctrl_pkg::DSEL_SER0_RX: r = e[irq_ctrl_pkg::BIT_SER0_RX];
			irq_ctrl_pkg::DSEL_ST3: r = e[irq_ctrl_pkg::BIT_ST3];
			irq_ctrl_pkg::DSEL_SR3: r = e[irq_ctrl_pkg::BIT_SR3];
			default: r = 1'b0;
		endcase
		return r;
	endfunction : sel_hit

	// ----------------------------------------------------------------
	// Event gathering
	// ----------------------------------------------------------------
	// Pack every source event into the flag layout
	always_comb begin
		evt = '0;
		evt[irq_ctrl_pkg::BIT_WDT] = watchdog_interval_irq;
		evt[irq_ctrl_pkg::BIT_LVI] = low_voltage_irq;
		evt[irq_ctrl_pkg::BIT_PIN0 +: irq_ctrl_pkg::NUM_PIN] = pin_evt;
		evt[irq_ctrl_pkg::BIT_ST3] = ser3_tx_end_irq;
		evt[irq_ctrl_pkg::BIT_SR3] = ser3_rx_end_irq;
		evt[irq_ctrl_pkg::BIT_SRE3] = ser3_rx_err_irq;
		evt[irq_ctrl_pkg::BIT_DMA0] = dma_done0;
		evt[irq_ctrl_pkg::BIT_DMA1] = dma_done1;
		evt[irq_ctrl_pkg::BIT_SER0_TX] = async0_tx_end_irq | sync_ser0_end_irq;
		evt[irq_ctrl_pkg::BIT_SER0_RX] = async0_rx_end_irq | sync_ser1_end_irq;
		evt[irq_ctrl_pkg::BIT_SRE0] = ser0_rx_err_irq;
	end

	// ----------------------------------------------------------------
	// Register read decode
	// ----------------------------------------------------------------
	// the six register kinds plus block status, clear and enable
	always_comb begin
		rd_mux = '0;
		rd_hit = 1'b1;
		unique case (paddr)
			irq_ctrl_pkg::OFS_REQ_LO: rd_mux[7:0] = s_r.req[7:0];
			irq_ctrl_pkg::OFS_REQ_HI: rd_mux[7:0] = s_r.req[15:8];
			irq_ctrl_pkg::OFS_MASK_LO: rd_mux[7:0] = s_r.mask[7:0];
			irq_ctrl_pkg::OFS_MASK_HI: rd_mux[7:0] = s_r.mask[15:8];
			irq_ctrl_pkg::OFS_PRIO_A_LO: rd_mux[7:0] = s_r.pa[7:0];
			irq_ctrl_pkg::OFS_PRIO_A_HI: rd_mux[7:0] = s_r.pa[15:8];
			irq_ctrl_pkg::OFS_PRIO_B_LO: rd_mux[7:0] = s_r.pb[7:0];
			irq_ctrl_pkg::OFS_PRIO_B_HI: rd_mux[7:0] = s_r.pb[15:8];
			irq_ctrl_pkg::OFS_RISE: rd_mux[5:0] = s_r.rise;
			irq_ctrl_pkg::OFS_FALL: rd_mux[5:0] = s_r.fall;
			irq_ctrl_pkg::OFS_CPU_STAT: rd_mux[7:0] = s_r.cpu_stat;
			irq_ctrl_pkg::OFS_DMODE0: rd_mux[7:0] = s_r.dmode0;
			irq_ctrl_pkg::OFS_DMODE1: rd_mux[7:0] = s_r.dmode1;
			irq_ctrl_pkg::OFS_STAT: rd_mux[1:0] = s_r.stat;
			// Clear register reads as zero
			irq_ctrl_pkg::OFS_CLR: rd_mux = '0;
			irq_ctrl_pkg::OFS_IEN: rd_mux[1:0] = s_r.ien;
			default: rd_hit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		// Zero-wait slave: ready rises in the access phase
		wr = psel & penable & s_r.rdy & pwrite & rd_hit;

		// Bus answer, prepared during the setup cycle
		s_nxt.rdy = psel & ~penable;
		s_nxt.err = psel & ~penable & ~rd_hit;
		if (psel & ~penable) begin
			s_nxt.rdata = pwrite ? 32'h0000_0000 : rd_mux;
		end

		// Software writes to plain fields
		req_base = s_r.req;
		if (wr) begin
			unique case (paddr)
				irq_ctrl_pkg::OFS_REQ_LO: req_base[7:0] = pwdata[7:0];
				irq_ctrl_pkg::OFS_REQ_HI: req_base[15:8] = pwdata[7:0];
				irq_ctrl_pkg::OFS_MASK_LO: s_nxt.mask[7:0] = pwdata[7:0];
				irq_ctrl_pkg::OFS_MASK_HI: s_nxt.mask[15:8] = pwdata[7:0];
				irq_ctrl_pkg::OFS_PRIO_A_LO: s_nxt.pa[7:0] = pwdata[7:0];
				irq_ctrl_pkg::OFS_PRIO_A_HI: s_nxt.pa[15:8] = pwdata[7:0];
				irq_ctrl_pkg::OFS_PRIO_B_LO: s_nxt.pb[7:0] = pwdata[7:0];
				irq_ctrl_pkg::OFS_PRIO_B_HI: s_nxt.pb[15:8] = pwdata[7:0];
				irq_ctrl_pkg::OFS_RISE: s_nxt.rise = pwdata[5:0];
				irq_ctrl_pkg::OFS_FALL: s_nxt.fall = pwdata[5:0];
				irq_ctrl_pkg::OFS_CPU_STAT: s_nxt.cpu_stat = pwdata[7:0];
				irq_ctrl_pkg::OFS_DMODE0: s_nxt.dmode0 = pwdata[7:0];
				irq_ctrl_pkg::OFS_DMODE1: s_nxt.dmode1 = pwdata[7:0];
				irq_ctrl_pkg::OFS_IEN: s_nxt.ien = pwdata[1:0];
				default: ;
			endcase
		end

		// Flags: CPU acknowledge clears one, new events always win
		ack_clr = cpu_ack ? (16'h0001 << cpu_ack_idx) : 16'h0000;
		s_nxt.req = (req_base & ~ack_clr) | evt;

		// DMA triggers from the same events that latch the flags
		// select field bits 3..0
		trig0 = s_r.dmode0[irq_ctrl_pkg::DMODE_EN_BIT] & sel_hit(s_r.dmode0[3:0], evt);
		trig1 = s_r.dmode1[irq_ctrl_pkg::DMODE_EN_BIT] & sel_hit(s_r.dmode1[3:0], evt);
		same = s_r.dmode0[irq_ctrl_pkg::DMODE_EN_BIT]
			& s_r.dmode1[irq_ctrl_pkg::DMODE_EN_BIT]
			& (s_r.dmode0[3:0] == s_r.dmode1[3:0]);

		s_nxt.dreq0 = (s_r.dreq0 & ~dma_done0) | trig0;
		// on a shared trigger, channel 1 waits for channel 0
		if (same) begin
			s_nxt.pend1 = (s_r.pend1 & ~dma_done0) | trig1;
			s_nxt.dreq1 = (s_r.dreq1 & ~dma_done1) | (s_r.pend1 & dma_done0);
		end else begin
			s_nxt.pend1 = 1'b0;
			s_nxt.dreq1 = (s_r.dreq1 & ~dma_done1) | trig1;
		end

		// Block status: set wins over a clear in the same cycle
		st_evt[irq_ctrl_pkg::ST_OVERRUN] = (trig0 & s_r.dreq0)
			| (trig1 & (s_r.dreq1 | s_r.pend1));
		st_evt[irq_ctrl_pkg::ST_LOST] = |(evt & s_r.req);
		s_nxt.stat = s_r.stat;
		if (wr && (paddr == irq_ctrl_pkg::OFS_CLR)) begin
			s_nxt.stat = s_r.stat & ~pwdata[1:0];
		end
		s_nxt.stat = s_nxt.stat | st_evt;
		s_nxt.intr = |(s_nxt.stat & s_nxt.ien);

		// Best pending source: lowest level code, then lowest index
		// set and unmasked only
		pend_v = s_nxt.req & ~s_nxt.mask;
		found = 1'b0;
		best_lvl = 2'h3;
		best_idx = 4'h0;
		for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (pend_v[i] && (!found || ({s_nxt.pb[i], s_nxt.pa[i]} <= best_lvl))) begin
				found = 1'b1;
				best_lvl = {s_nxt.pb[i], s_nxt.pa[i]};
				best_idx = 4'(i);
			end
		end
		// Accept only with interrupts enabled and level within service limit
		s_nxt.irq = found & s_nxt.cpu_stat[irq_ctrl_pkg::CPU_STAT_IE_BIT]
			& (best_lvl <= s_nxt.cpu_stat[irq_ctrl_pkg::CPU_STAT_ISP_LSB +: 2]);
		s_nxt.idx = best_idx;
		s_nxt.lvl = best_lvl;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= RST_STATE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign prdata = s_r.rdata;
	assign pready = s_r.rdy;
	assign pslverr = s_r.err;
	assign dma_req0 = s_r.dreq0;
	assign dma_req1 = s_r.dreq1;
	assign irq_req = s_r.irq;
	assign irq_idx = s_r.idx;
	assign irq_lvl = s_r.lvl;
	assign int_out = s_r.intr;

endmodule : irq_flag_ctrl

// ===== sim/irq_ctrl_monitor.sv
// Port-level checker for the interrupt flag, mask and DMA trigger block
`timescale 1ns/1ps
module irq_ctrl_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic async0_tx_end_irq,
	input wire logic sync_ser0_end_irq,
	input wire logic dma_done0,
	input wire logic dma_done1,
	input wire logic dma_req0,
	input wire logic dma_req1,
	input wire logic irq_req,
	input wire logic int_out
);
	// ----------------------------------------------------------------
	// Helper logic: copies of what software wrote
	// ----------------------------------------------------------------
	logic wr; // Write completing at this edge
	logic [7:0] m0_r; // Channel 0 mode copy
	logic [7:0] m1_r; // Channel 1 mode copy
	logic ie_r; // Global enable copy
	assign wr = psel && penable && pready && pwrite;
	// Snoop writes so triggers can be judged without seeing the bodies
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m0_r <= 8'h00;
			m1_r <= 8'h00;
			ie_r <= 1'b0;
		end else if (wr) begin
			if (paddr == irq_ctrl_pkg::OFS_DMODE0) m0_r <= pwdata[7:0];
			if (paddr == irq_ctrl_pkg::OFS_DMODE1) m1_r <= pwdata[7:0];
			if (paddr == irq_ctrl_pkg::OFS_CPU_STAT) ie_r <= pwdata[7];
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not one access cycle");
	chk_unmapped_err: assert property (psel && !penable && paddr > 8'h3c |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	chk_enable_gates_req: assert property ($rose(irq_req) |-> ie_r)
		else $error("request raised with global enable off");
	chk_dma_same_cycle: assert property ((sync_ser0_end_irq || async0_tx_end_irq) && m0_r == 8'h86 && !dma_done0 |=> dma_req0)
		else $error("dma request late");
	chk_dma_holds: assert property (dma_req0 && !dma_done0 |=> dma_req0)
		else $error("dma request dropped early");
	chk_dma_order: assert property ($rose(dma_req1) && m0_r == m1_r && m0_r[7] |-> $past(dma_done0))
		else $error("channel 1 started before channel 0 ended");
	chk_done_drops: assert property (dma_done1 && !dma_done0 && !sync_ser0_end_irq && !async0_tx_end_irq |=> !dma_req1)
		else $error("channel 1 request not dropped");
	chk_status_sticky: assert property ($fell(int_out) |-> $past(wr) || $past(wr, 2))
		else $error("status interrupt fell without a write");
endmodule : irq_ctrl_monitor

// ===== sim/dma_service_model.sv
// Behavioural DMA channel answering a start request after a set latency
`timescale 1ns/1ps
module dma_service_model #(
	parameter int LAT = 3 // Transfer cycles before the finish pulse
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req,
	output logic done
);
	logic [7:0] cnt_r; // Cycles spent on this request
	// Finish pulse lasts one cycle, then the count restarts if the request is still high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 8'h00;
			done <= 1'b0;
		end else if (req && !done) begin
			cnt_r <= cnt_r + 8'h01;
			done <= (cnt_r == LAT[7:0] - 8'h01);
		end else begin
			cnt_r <= 8'h00;
			done <= 1'b0;
		end
	end
endmodule : dma_service_model

// ===== sim/tb_top.sv
// Self-checking bench for the interrupt flag block
`timescale 1ns/1ps
module tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [9:0] ev = 10'h000; // Event pulses, one per source input
	logic [5:0] pin = 6'h00; // External pin levels
	logic cpu_ack = 1'b0;
	logic [3:0] cpu_ack_idx = 4'h0;
	logic [31:0] prdata;
	logic pready, pslverr, done0, done1, req0, req1, irq_req, int_out;
	logic [3:0] irq_idx;
	logic [1:0] irq_lvl;
	logic [31:0] rdat; // Last read data
	logic rerr; // Last slave error
	int fails = 0;
	int checks_done = 0;
	int n;
	int i;
	int b;
	// Reset value per word offset 0x00..0x3c
	logic [7:0] rv[16] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// Flag bit set by each event input
	int bit_of[10] = '{irq_ctrl_pkg::BIT_WDT, irq_ctrl_pkg::BIT_LVI, irq_ctrl_pkg::BIT_ST3,
		irq_ctrl_pkg::BIT_SR3, irq_ctrl_pkg::BIT_SRE3, irq_ctrl_pkg::BIT_SER0_TX,
		irq_ctrl_pkg::BIT_SER0_TX, irq_ctrl_pkg::BIT_SER0_RX, irq_ctrl_pkg::BIT_SER0_RX,
		irq_ctrl_pkg::BIT_SRE0};
	// ----------------------------------------------------------------
	// Design, partner channels and clock
	// ----------------------------------------------------------------
	irq_flag_ctrl i_irq_flag_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .watchdog_interval_irq(ev[0]),
		.low_voltage_irq(ev[1]), .ser3_tx_end_irq(ev[2]), .ser3_rx_end_irq(ev[3]),
		.ser3_rx_err_irq(ev[4]), .async0_tx_end_irq(ev[5]), .sync_ser0_end_irq(ev[6]),
		.async0_rx_end_irq(ev[7]), .sync_ser1_end_irq(ev[8]), .ser0_rx_err_irq(ev[9]),
		.pin_irq(pin), .dma_done0(done0), .dma_done1(done1), .dma_req0(req0), .dma_req1(req1),
		.cpu_ack(cpu_ack), .cpu_ack_idx(cpu_ack_idx), .irq_req(irq_req), .irq_idx(irq_idx),
		.irq_lvl(irq_lvl), .int_out(int_out));
	// Channel 0 answers promptly, channel 1 slowly
	dma_service_model #(.LAT(3)) i_dma_service_model_0 (.pclk(pclk), .presetn(presetn),
		.req(req0), .done(done0));
	dma_service_model #(.LAT(6)) i_dma_service_model_1 (.pclk(pclk), .presetn(presetn),
		.req(req1), .done(done1));
	initial begin
		forever #2.5 pclk = ~pclk;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [7:0] id);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t item %h got %h exp %h", $time, id, got, exp);
		end
	endtask : chk
	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			fails++;
			close_out();
		end
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdat, exp, a);
	endtask : rd
	task automatic pulse(input int k);
		@(posedge pclk);
		ev <= 10'h001 << k;
		@(posedge pclk);
		ev <= 10'h000;
	endtask : pulse
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 16; i++) rd(8'(i * 4), {24'h0, rv[i]});
		// Upper data bits ignored; status and clear read back zero
		for (i = 2; i < 16; i++) begin
			apb(1'b1, 8'(i * 4), 32'h1234_565a);
			rd(8'(i * 4), (i == 13 || i == 14) ? 32'h0000_0000 : (i == 15) ? 32'h0000_0002
				: (i == 8 || i == 9) ? 32'h0000_001a : 32'h0000_005a);
			apb(1'b1, 8'(i * 4), {24'h0, rv[i]});
		end
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk({31'h0, rerr}, 32'h0000_0001, 8'h40);
		$display("test registers done");
		// Shared serial sources are never pulsed together
		// one event at a time
		for (i = 0; i < 10; i++) begin
			b = bit_of[i];
			pulse(i);
			rd((b < 8) ? 8'h00 : 8'h04, 32'h0000_0001 << (b % 8));
			apb(1'b1, (b < 8) ? 8'h00 : 8'h04, 32'h0000_0000);
		end
		$display("test events done");
		apb(1'b1, irq_ctrl_pkg::OFS_CPU_STAT, 32'h0000_0086);
		pulse(6);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq_req}, 32'h0000_0000, 8'h01);
		apb(1'b1, irq_ctrl_pkg::OFS_MASK_HI, 32'h0000_00df);
		repeat (2) @(posedge pclk);
		chk({25'h0, irq_req, irq_idx, irq_lvl}, 32'h0000_0077, 8'h02);
		@(posedge pclk);
		cpu_ack <= 1'b1;
		cpu_ack_idx <= 4'hd;
		@(posedge pclk);
		cpu_ack <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({31'h0, irq_req}, 32'h0000_0000, 8'h03);
		rd(irq_ctrl_pkg::OFS_REQ_HI, 32'h0000_0000);
		apb(1'b1, irq_ctrl_pkg::OFS_MASK_HI, 32'h0000_00ff);
		$display("test cpu done");
		apb(1'b1, irq_ctrl_pkg::OFS_RISE, 32'h0000_0001);
		apb(1'b1, irq_ctrl_pkg::OFS_FALL, 32'h0000_0002);
		pin <= 6'h01;
		repeat (6) @(posedge pclk);
		pin <= 6'h03;
		repeat (6) @(posedge pclk);
		rd(irq_ctrl_pkg::OFS_REQ_LO, 32'h0000_0004);
		pin <= 6'h01;
		repeat (6) @(posedge pclk);
		rd(irq_ctrl_pkg::OFS_REQ_LO, 32'h0000_000c);
		apb(1'b1, irq_ctrl_pkg::OFS_REQ_LO, 32'h0000_0000);
		$display("test pins done");
		apb(1'b1, irq_ctrl_pkg::OFS_DMODE0, 32'h0000_0086);
		apb(1'b1, irq_ctrl_pkg::OFS_DMODE1, 32'h0000_0086);
		pulse(6);
		@(posedge pclk);
		chk({30'h0, req1, req0}, 32'h0000_0001, 8'h10);
		n = 0;
		while (req1 !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		chk({30'h0, req1, req0}, 32'h0000_0002, 8'h11);
		while (req1 !== 1'b0 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 50) begin
			fails++;
			close_out();
		end
		// Channel 1 alone on the shared receive code
		apb(1'b1, irq_ctrl_pkg::OFS_DMODE1, 32'h0000_0087);
		pulse(8);
		@(posedge pclk);
		chk({30'h0, req1, req0}, 32'h0000_0002, 8'h12);
		$display("test dma done");
		apb(1'b1, irq_ctrl_pkg::OFS_CLR, 32'h0000_0003);
		pulse(0);
		pulse(0);
		rd(irq_ctrl_pkg::OFS_STAT, 32'h0000_0002);
		apb(1'b1, irq_ctrl_pkg::OFS_IEN, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		chk({31'h0, int_out}, 32'h0000_0001, 8'h20);
		apb(1'b1, irq_ctrl_pkg::OFS_IEN, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		chk({31'h0, int_out}, 32'h0000_0000, 8'h21);
		apb(1'b1, irq_ctrl_pkg::OFS_IEN, 32'h0000_0002);
		apb(1'b1, irq_ctrl_pkg::OFS_CLR, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		chk({31'h0, int_out}, 32'h0000_0000, 8'h22);
		rd(irq_ctrl_pkg::OFS_STAT, 32'h0000_0000);
		$display("test status done");
		close_out();
	end
endmodule : tb_top
bind irq_flag_ctrl irq_ctrl_monitor i_irq_ctrl_monitor (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .async0_tx_end_irq,
	.sync_ser0_end_irq, .dma_done0, .dma_done1, .dma_req0, .dma_req1, .irq_req, .int_out);
